// ---- shared/tmw_pkg.sv ----
// Constants and types shared by the 8-bit timer waveform-mode logic
// How it works
// - Only the waveform mode picks the count sequence; output actions only shape outputs.
// - Normal mode counts up forever, wrapping 0xFF to 0x00, never clearing.
// - Normal mode sets the overflow flag as the count turns zero; never clears it.
// - Normal mode accepts a count write at any moment without special handling.
// - Mode 2 clears the count to zero when it equals compare value A.
// - Mode 2 uses compare A unbuffered; a value below count means a wrap first.
// - Mode 2 with action 1 toggles output A on each match.
// - Mode 2 sets the overflow flag when the count passes 0xFF to 0x00.
// - A waveform output reaches its pin only while the pin direction is output.
// - Modes 3 and 7 count bottom to top, restart; top 0xFF or compare A.
// - Fast PWM increments up to top, then clears on the following tick.
// - Fast PWM sets the overflow flag each time the count reaches top.
// - Fast PWM action 2 clears on match, sets at top-to-bottom; action 3 opposite.
// - Fast PWM action 1 toggles output A only with mode bit 2; never output B.
// - Fast PWM compare A at bottom spikes one tick; at max a constant level.
// - Modes 1 and 5 count up to top then down to bottom; top 0xFF or A.
// - Phase-correct holds top for exactly one tick, then reverses direction.
// - Phase-correct sets the overflow flag each time the count reaches bottom.
// - Phase-correct action 2 clears on up match, sets on down match; 3 reversed.
// - Phase-correct action 1 toggles output A only with mode bit 2; never B.
// - Phase-correct action 2 compare at bottom gives steady low, at max steady high; action 3 the reverse.
// - Phase-correct forces the up-match result at bottom when a match was missed.
// - PWM modes double-buffer compare writes, loading at top; others write directly.
// - A compare flag sets on the tick after the count equals its compare value.
// - Clock select zero stops counting; a count write beats clear or count.
// - Action code zero disconnects the output and takes no match action.
`default_nettype none

package tmw_pkg;
   localparam int unsigned CNT_W = 8;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic [2:0] CLK_STOPPED = 3'h0;
   localparam int unsigned MODE_BIT2 = 2;
   // Waveform mode codes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PC_FF = 3'h1;
   localparam logic [2:0] WM_CTC = 3'h2;
   localparam logic [2:0] WM_FAST_FF = 3'h3;
   localparam logic [2:0] WM_PC_A = 3'h5;
   localparam logic [2:0] WM_FAST_A = 3'h7;
   // Output action codes
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam int unsigned ACT_HI = 1;

   typedef enum logic [3:0]
   {
      CLS_NORMAL = 4'b0001,
      CLS_CTC = 4'b0010,
      CLS_FAST = 4'b0100,
      CLS_PC = 4'b1000
   } tmw_class_t;
endpackage : tmw_pkg

`default_nettype wire

// ---- rtl/tmw_timer8.sv ----
// 8-bit timer counter with normal, clear-on-match, fast and phase-correct PWM modes
`timescale 1ns/1ps
`default_nettype none

module tmw_timer8
   import tmw_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic [2:0] clock_source_select_i,
   input wire logic [2:0] waveform_mode_select_i,
   input wire logic [1:0] output_a_action_select_i,
   input wire logic [1:0] output_b_action_select_i,
   input wire logic count_wr_i,
   input wire logic [7:0] count_wdata_i,
   input wire logic compare_a_wr_i,
   input wire logic compare_b_wr_i,
   input wire logic [7:0] compare_wdata_i,
   input wire logic overflow_clear_i,
   input wire logic compare_flag_a_clear_i,
   input wire logic compare_flag_b_clear_i,
   input wire logic pin_a_dir_out_i,
   input wire logic pin_b_dir_out_i,
   input wire logic pin_a_port_i,
   input wire logic pin_b_port_i,
   output logic [7:0] count_value_o,
   output logic [7:0] compare_value_a_o,
   output logic [7:0] compare_value_b_o,
   output logic counting_down_o,
   output logic overflow_flag_o,
   output logic compare_flag_a_o,
   output logic compare_flag_b_o,
   output logic wave_out_a_o,
   output logic wave_out_b_o,
   output logic pin_a_o,
   output logic pin_a_oe_o,
   output logic pin_b_o,
   output logic pin_b_oe_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] cnt_q;
   logic down_q;
   logic [7:0] cmp_a_q;
   logic [7:0] cmp_b_q;
   logic [7:0] buf_a_q;
   logic [7:0] buf_b_q;
   logic block_q;
   logic ovf_q;
   logic flag_a_q;
   logic flag_b_q;
   logic wave_a_q;
   logic wave_b_q;
   logic seen_down_a_q;
   logic seen_down_b_q;

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   tmw_class_t cls;
   logic [7:0] top;
   logic step;
   logic is_pwm;
   logic at_top;
   logic at_bottom;
   logic match_a;
   logic match_b;
   logic a_eq_top;
   logic b_eq_top;
   logic wrap_up;
   logic pc_bottom;

   always_comb
   begin
      // Reserved mode codes fall back to plain up-counting
      case (waveform_mode_select_i)
         WM_CTC:
            cls = CLS_CTC;
         WM_FAST_FF, WM_FAST_A:
            cls = CLS_FAST;
         WM_PC_FF, WM_PC_A:
            cls = CLS_PC;
         default:
            cls = CLS_NORMAL;
      endcase
   end

   // Top follows the mode only; action codes never enter here
   assign top = (cls == CLS_CTC || waveform_mode_select_i[MODE_BIT2]) ? cmp_a_q : CNT_MAX;
   assign is_pwm = (cls == CLS_FAST) || (cls == CLS_PC);
   assign step = tick_i && (clock_source_select_i != CLK_STOPPED);
   assign at_top = (cnt_q == top);
   assign at_bottom = (cnt_q == CNT_BOTTOM);
   // A count write hides the match of the next timer tick
   assign match_a = (cnt_q == cmp_a_q) && !block_q;
   assign match_b = (cnt_q == cmp_b_q) && !block_q;
   assign a_eq_top = (cmp_a_q == top);
   assign b_eq_top = (cmp_b_q == top);
   assign wrap_up = (cls == CLS_FAST) && at_top;
   assign pc_bottom = (cls == CLS_PC) && down_q && at_bottom;

   // ------------------------------------------------------------
   // Counter and direction
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cnt_q <= CNT_RESET;
      end
      else if (count_wr_i)
      begin
         cnt_q <= count_wdata_i;
      end
      else if (step)
      begin
         case (cls)
            CLS_CTC:
               cnt_q <= (cnt_q == cmp_a_q) ? CNT_BOTTOM : cnt_q + 8'h01;
            CLS_FAST:
               cnt_q <= at_top ? CNT_BOTTOM : cnt_q + 8'h01;
            CLS_PC:
            begin
               // Top is held one tick: reversal happens on the tick that leaves it
               if (top == CNT_BOTTOM)
                  cnt_q <= CNT_BOTTOM;
               else if (!down_q && cnt_q >= top)
                  cnt_q <= cnt_q - 8'h01;
               else if (down_q && at_bottom)
                  cnt_q <= cnt_q + 8'h01;
               else if (down_q)
                  cnt_q <= cnt_q - 8'h01;
               else
                  cnt_q <= cnt_q + 8'h01;
            end
            default:
               cnt_q <= cnt_q + 8'h01;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         down_q <= 1'b0;
      else if (cls != CLS_PC)
         down_q <= 1'b0;
      else if (step && !count_wr_i)
      begin
         if (!down_q && cnt_q >= top && top != CNT_BOTTOM)
            down_q <= 1'b1;
         else if (down_q && at_bottom)
            down_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         block_q <= 1'b0;
      else if (count_wr_i)
         block_q <= 1'b1;
      else if (step)
         block_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // Compare values, buffered only in PWM modes
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         buf_a_q <= CMP_RESET;
         buf_b_q <= CMP_RESET;
      end
      else
      begin
         if (compare_a_wr_i)
            buf_a_q <= compare_wdata_i;
         if (compare_b_wr_i)
            buf_b_q <= compare_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cmp_a_q <= CMP_RESET;
         cmp_b_q <= CMP_RESET;
      end
      else if (!is_pwm)
      begin
         // Direct writes: a value below the count is missed until a wrap
         if (compare_a_wr_i)
            cmp_a_q <= compare_wdata_i;
         if (compare_b_wr_i)
            cmp_b_q <= compare_wdata_i;
      end
      else if (step && !count_wr_i && at_top && !down_q)
      begin
         // Loading only at top keeps every period whole
         cmp_a_q <= buf_a_q;
         cmp_b_q <= buf_b_q;
      end
   end

   // ------------------------------------------------------------
   // Flags: a hardware set in the clearing cycle wins
   // ------------------------------------------------------------
   logic ovf_event;

   always_comb
   begin
      case (cls)
         CLS_FAST:
            ovf_event = at_top;
         CLS_PC:
            ovf_event = at_bottom;
         default:
            ovf_event = (cnt_q == CNT_MAX);
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         ovf_q <= 1'b0;
      else if (step && !count_wr_i && ovf_event)
         ovf_q <= 1'b1;
      else if (overflow_clear_i)
         ovf_q <= 1'b0;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         flag_a_q <= 1'b0;
         flag_b_q <= 1'b0;
      end
      else
      begin
         if (step && match_a)
            flag_a_q <= 1'b1;
         else if (compare_flag_a_clear_i)
            flag_a_q <= 1'b0;
         if (step && match_b)
            flag_b_q <= 1'b1;
         else if (compare_flag_b_clear_i)
            flag_b_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Waveform outputs
   // ------------------------------------------------------------
   function automatic logic wave_next(
      input logic cur,
      input logic [1:0] act,
      input logic match,
      input logic eq_top,
      input logic may_toggle,
      input logic seen_down
   );
      logic nxt;
      nxt = cur;
      if (act == ACT_OFF)
         nxt = cur;
      else if (act == ACT_TOGGLE)
      begin
         if (match && (cls == CLS_NORMAL || cls == CLS_CTC || may_toggle))
            nxt = !cur;
      end
      else if (cls == CLS_NORMAL || cls == CLS_CTC)
      begin
         if (match)
            nxt = act[0];
      end
      else if (cls == CLS_FAST)
      begin
         // Match at top is ignored; the top action sets the steady level
         if (wrap_up)
            nxt = !act[0];
         else if (match && !eq_top)
            nxt = act[0];
      end
      else
      begin
         if (!down_q && at_top && eq_top)
            nxt = !act[0];
         else if (pc_bottom && !seen_down && !eq_top)
            nxt = act[0];
         else if (match && !eq_top)
            nxt = down_q ? !act[0] : act[0];
      end
      return nxt;
   endfunction : wave_next

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end
      else if (step)
      begin
         wave_a_q <= wave_next(wave_a_q, output_a_action_select_i, match_a, a_eq_top,
                               waveform_mode_select_i[MODE_BIT2], seen_down_a_q);
         wave_b_q <= wave_next(wave_b_q, output_b_action_select_i, match_b, b_eq_top,
                               1'b0, seen_down_b_q);
      end
   end

   // Remembers a down-slope match so a missed one can be repaired at bottom
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         seen_down_a_q <= 1'b0;
         seen_down_b_q <= 1'b0;
      end
      else if (step)
      begin
         if (pc_bottom || !down_q)
            seen_down_a_q <= 1'b0;
         else if (match_a)
            seen_down_a_q <= 1'b1;
         if (pc_bottom || !down_q)
            seen_down_b_q <= 1'b0;
         else if (match_b)
            seen_down_b_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Pin override
   // ------------------------------------------------------------
   assign pin_a_oe_o = pin_a_dir_out_i;
   assign pin_b_oe_o = pin_b_dir_out_i;
   assign pin_a_o = (output_a_action_select_i != ACT_OFF) ? wave_a_q : pin_a_port_i;
   assign pin_b_o = (output_b_action_select_i != ACT_OFF) ? wave_b_q : pin_b_port_i;

   assign count_value_o = cnt_q;
   assign compare_value_a_o = cmp_a_q;
   assign compare_value_b_o = cmp_b_q;
   assign counting_down_o = down_q;
   assign overflow_flag_o = ovf_q;
   assign compare_flag_a_o = flag_a_q;
   assign compare_flag_b_o = flag_b_q;
   assign wave_out_a_o = wave_a_q;
   assign wave_out_b_o = wave_b_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_write;
      count_wr_i;
   endsequence

   sequence s_top_tick;
      step && !count_wr_i && cls == CLS_FAST && at_top;
   endsequence

   normal_wrap_a: assert property (step && !count_wr_i && cls == CLS_NORMAL && cnt_q == CNT_MAX
      |=> cnt_q == CNT_BOTTOM && ovf_q)
      else $error("normal mode did not wrap with overflow");
   write_prio_a: assert property (s_write |=> cnt_q == $past(count_wdata_i))
      else $error("count write lost");
   stopped_hold_a: assert property (!count_wr_i && clock_source_select_i == CLK_STOPPED
      |=> $stable(cnt_q))
      else $error("counter moved while stopped");
   ctc_clear_a: assert property (step && !count_wr_i && cls == CLS_CTC && cnt_q == cmp_a_q
      |=> cnt_q == CNT_BOTTOM)
      else $error("match did not clear count");
   fast_restart_a: assert property (s_top_tick |=> cnt_q == CNT_BOTTOM && ovf_q)
      else $error("fast mode did not restart at top");
   flag_after_a: assert property (step && match_a |=> flag_a_q)
      else $error("compare flag A not set");
   pc_turn_a: assert property (step && !count_wr_i && cls == CLS_PC && !down_q && at_top
      && top != CNT_BOTTOM && !compare_a_wr_i |=> down_q && cnt_q == $past(cnt_q) - 8'h01)
      else $error("phase-correct top not reversed");
   off_quiet_a: assert property (output_b_action_select_i == ACT_OFF |=> $stable(wave_b_q))
      else $error("disconnected output changed");
   pin_gate_a: assert property (pin_a_oe_o == pin_a_dir_out_i)
      else $error("pin enable not from direction");
endmodule : tmw_timer8

`default_nettype wire

// ---- verification/tmw_pin_load.sv ----
// Load model for one timer waveform pin
`timescale 1ns/1ps
`default_nettype none

module tmw_pin_load #(
   parameter logic PULL_LEVEL = 1'b0
)
(
   input wire logic drive_i,
   input wire logic oe_i,
   output logic level_o
);
   // A released pin settles to the pull level, so a stale drive never looks valid
   assign level_o = oe_i ? drive_i : PULL_LEVEL;
endmodule : tmw_pin_load

`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the 8-bit timer waveform-mode logic
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import tmw_pkg::*;
   logic clk_sys_i, rst_i, tick_i, count_wr_i, compare_a_wr_i, compare_b_wr_i;
   logic [2:0] clock_source_select_i, waveform_mode_select_i;
   logic [1:0] output_a_action_select_i, output_b_action_select_i;
   logic [7:0] count_wdata_i, compare_wdata_i;
   logic overflow_clear_i, compare_flag_a_clear_i, compare_flag_b_clear_i;
   logic pin_a_dir_out_i, pin_b_dir_out_i, pin_a_port_i, pin_b_port_i;
   logic [7:0] count_value_o, compare_value_a_o, compare_value_b_o;
   logic counting_down_o, overflow_flag_o, compare_flag_a_o, compare_flag_b_o;
   logic wave_out_a_o, wave_out_b_o, pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o;
   logic load_a, load_b;
   logic [7:0] exp_q[$];
   logic [7:0] ec, cmpa, w;
   logic ed;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   integer seed = 32'h7720;

   tmw_timer8 i_tmw_timer8 (.clk_sys_i, .rst_i, .tick_i, .clock_source_select_i,
      .waveform_mode_select_i, .output_a_action_select_i, .output_b_action_select_i,
      .count_wr_i, .count_wdata_i, .compare_a_wr_i, .compare_b_wr_i, .compare_wdata_i,
      .overflow_clear_i, .compare_flag_a_clear_i, .compare_flag_b_clear_i,
      .pin_a_dir_out_i, .pin_b_dir_out_i, .pin_a_port_i, .pin_b_port_i, .count_value_o,
      .compare_value_a_o, .compare_value_b_o, .counting_down_o, .overflow_flag_o,
      .compare_flag_a_o, .compare_flag_b_o, .wave_out_a_o, .wave_out_b_o, .pin_a_o,
      .pin_a_oe_o, .pin_b_o, .pin_b_oe_o);
   tmw_pin_load i_tmw_pin_load_a (.drive_i(pin_a_o), .oe_i(pin_a_oe_o), .level_o(load_a));
   tmw_pin_load i_tmw_pin_load_b (.drive_i(pin_b_o), .oe_i(pin_b_oe_o), .level_o(load_b));

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic chb(input string nm, input logic e, input logic s);
      chk(nm, {7'h00, e}, {7'h00, s});
   endtask : chb

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // Reference count sequence; direction state lives in ed
   function automatic logic [7:0] nxt();
      logic [7:0] top;
      top = (waveform_mode_select_i inside {WM_FAST_A, WM_PC_A}) ? cmpa : CNT_MAX;
      if (clock_source_select_i == CLK_STOPPED)
         return ec;
      if (waveform_mode_select_i == WM_CTC)
         return (ec == cmpa) ? CNT_BOTTOM : ec + 8'h01;
      if (waveform_mode_select_i inside {WM_FAST_FF, WM_FAST_A})
         return (ec == top) ? CNT_BOTTOM : ec + 8'h01;
      if (waveform_mode_select_i inside {WM_PC_FF, WM_PC_A})
      begin
         if (!ed && ec == top)
            ed = 1'b1;
         else if (ed && ec == CNT_BOTTOM)
            ed = 1'b0;
         return ed ? ec - 8'h01 : ec + 8'h01;
      end
      return ec + 8'h01;
   endfunction : nxt

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic tick_n(input int n);
      repeat (n)
      begin
         @(negedge clk_sys_i);
         tick_i = 1'b1;
         ec = nxt();
         exp_q.push_back(ec);
         @(negedge clk_sys_i);
         tick_i = 1'b0;
      end
   endtask : tick_n

   task automatic wr(input logic c, input logic a, input logic b, input logic [7:0] v);
      @(negedge clk_sys_i);
      count_wr_i = c;
      compare_a_wr_i = a;
      compare_b_wr_i = b;
      count_wdata_i = v;
      compare_wdata_i = v;
      @(negedge clk_sys_i);
      count_wr_i = 1'b0;
      compare_a_wr_i = 1'b0;
      compare_b_wr_i = 1'b0;
      if (c)
         ec = v;
      if (a)
         cmpa = v;
   endtask : wr

   task automatic clr();
      @(negedge clk_sys_i);
      overflow_clear_i = 1'b1;
      compare_flag_a_clear_i = 1'b1;
      compare_flag_b_clear_i = 1'b1;
      @(negedge clk_sys_i);
      overflow_clear_i = 1'b0;
      compare_flag_a_clear_i = 1'b0;
      compare_flag_b_clear_i = 1'b0;
   endtask : clr

   // Scoreboard: each timer tick leaves one expected count in the queue
   always @(posedge clk_sys_i)
   begin
      if (tick_i === 1'b1 && exp_q.size() > 0)
      begin
         #1;
         chk("count", exp_q.pop_front(), count_value_o);
      end
   end

   initial
   begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // Ceiling is several times the expected run length
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_i, tick_i, count_wr_i, compare_a_wr_i, compare_b_wr_i} = 5'h1F;
      {tick_i, count_wr_i, compare_a_wr_i, compare_b_wr_i} = 4'h0;
      {clock_source_select_i, waveform_mode_select_i} = 6'h00;
      {output_a_action_select_i, output_b_action_select_i} = 4'h0;
      {count_wdata_i, compare_wdata_i} = 16'h0000;
      {overflow_clear_i, compare_flag_a_clear_i, compare_flag_b_clear_i} = 3'h0;
      {pin_a_dir_out_i, pin_b_dir_out_i, pin_a_port_i, pin_b_port_i} = 4'h0;
      ec = 8'h00;
      cmpa = 8'h00;
      ed = 1'b0;
      repeat (12) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      chk("count", CNT_RESET, count_value_o);
      chk("compare", CMP_RESET, compare_value_a_o | compare_value_b_o);
      chk("flags", 8'h00, {overflow_flag_o, compare_flag_a_o, compare_flag_b_o});
      chk("waves", 8'h00, {wave_out_a_o, wave_out_b_o, counting_down_o});
      clock_source_select_i = 3'h1;
      w = 8'($random(seed));
      wr(1'b1, 1'b0, 1'b0, w);
      tick_n(300);
      chb("overflow", 1'b1, overflow_flag_o);
      $display("test normal done");
      @(negedge clk_sys_i);
      clock_source_select_i = CLK_STOPPED;
      tick_n(3);
      @(negedge clk_sys_i);
      clock_source_select_i = 3'h1;
      count_wr_i = 1'b1;
      count_wdata_i = 8'h40;
      tick_i = 1'b1;
      exp_q.push_back(8'h40);
      @(negedge clk_sys_i);
      count_wr_i = 1'b0;
      tick_i = 1'b0;
      ec = 8'h40;
      $display("test stop and write priority done");
      wr(1'b0, 1'b1, 1'b0, 8'h02);
      wr(1'b1, 1'b0, 1'b0, 8'h00);
      waveform_mode_select_i = WM_CTC;
      output_a_action_select_i = ACT_TOGGLE;
      clr();
      tick_n(3);
      chb("wave a", 1'b1, wave_out_a_o);
      chb("flag a", 1'b1, compare_flag_a_o);
      tick_n(3);
      chb("wave a", 1'b0, wave_out_a_o);
      tick_n(2);
      wr(1'b0, 1'b1, 1'b0, 8'h01);
      tick_n(253);
      chb("overflow", 1'b0, overflow_flag_o);
      tick_n(1);
      chb("overflow", 1'b1, overflow_flag_o);
      $display("test clear on match done");
      wr(1'b0, 1'b1, 1'b1, 8'h10);
      waveform_mode_select_i = WM_FAST_FF;
      output_a_action_select_i = ACT_SET;
      output_b_action_select_i = ACT_CLEAR;
      wr(1'b1, 1'b0, 1'b0, 8'hFD);
      clr();
      tick_n(3);
      chk("top", 8'h05, {overflow_flag_o, wave_out_a_o, wave_out_b_o});
      tick_n(17);
      chk("match", 8'h06, {compare_flag_b_o, wave_out_a_o, wave_out_b_o});
      wr(1'b0, 1'b0, 1'b1, 8'h20);
      chk("compare b", 8'h10, compare_value_b_o);
      clr();
      tick_n(239);
      chk("compare b", 8'h20, compare_value_b_o);
      chb("overflow", 1'b1, overflow_flag_o);
      $display("test fast pwm done");
      waveform_mode_select_i = WM_PC_FF;
      output_b_action_select_i = ACT_SET;
      wr(1'b1, 1'b0, 1'b0, 8'h22);
      clr();
      tick_n(444);
      chb("down", 1'b1, counting_down_o);
      tick_n(1);
      chb("wave b", 1'b0, wave_out_b_o);
      tick_n(32);
      chk("bottom", 8'h02, {overflow_flag_o, counting_down_o});
      tick_n(32);
      chb("wave b", 1'b1, wave_out_b_o);
      $display("test phase correct done");
      // Compare A loaded while unbuffered so the model's top matches the active value
      waveform_mode_select_i = WM_NORMAL;
      wr(1'b0, 1'b1, 1'b1, 8'h04);
      wr(1'b1, 1'b0, 1'b0, 8'h00);
      {waveform_mode_select_i, output_a_action_select_i, output_b_action_select_i} =
         {WM_FAST_A, ACT_TOGGLE, ACT_TOGGLE};
      tick_n(5);
      chk("toggle", 8'h01, {wave_out_a_o, wave_out_b_o});
      tick_n(5);
      chk("toggle", 8'h03, {wave_out_a_o, wave_out_b_o});
      $display("test fast top a done");
      waveform_mode_select_i = WM_PC_A;
      tick_n(8);
      chk("pc top a", 8'h03, {wave_out_a_o, wave_out_b_o, counting_down_o});
      tick_n(1);
      chb("down", 1'b0, counting_down_o);
      $display("test phase correct top a done");
      @(negedge clk_sys_i);
      pin_b_dir_out_i = 1'b1;
      #1;
      chb("pin b", 1'b1, load_b);
      @(negedge clk_sys_i);
      pin_b_dir_out_i = 1'b0;
      #1;
      chb("pin b", 1'b0, load_b);
      @(negedge clk_sys_i);
      {pin_b_dir_out_i, output_b_action_select_i} = {1'b1, ACT_OFF};
      #1;
      chb("pin b", 1'b0, load_b);
      @(negedge clk_sys_i);
      {pin_a_dir_out_i, output_a_action_select_i, pin_a_port_i} = {1'b1, ACT_OFF, 1'b1};
      #1;
      chb("pin a", 1'b1, load_a);
      $display("test pins done");
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire
